// [src/adcc_pkg.sv]
`default_nettype none
package adcc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL0 = 5'h00;
  localparam logic [4:0] OFS_CTRL1 = 5'h04;
  localparam logic [4:0] OFS_CTRL2 = 5'h08;
  localparam logic [4:0] OFS_RESH = 5'h0c;
  localparam logic [4:0] OFS_RESL = 5'h10;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h14;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h18;
  localparam logic [4:0] OFS_GIE = 5'h1c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CH_LSB = 0;
  localparam int PWR_BIT = 4;
  localparam int BUSY_BIT = 5;
  localparam int START_BIT = 6;
  localparam int DIV_LSB = 0;
  localparam int FMT_BIT = 3;
  localparam int INS_LSB = 4;
  localparam int REF_LSB = 0;
  localparam int FLAG_BIT = 0;

  // ----------------------------------------------------------------
  // Encodings and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] REF_VDD = 2'h0;
  localparam logic [1:0] REF_PIN = 2'h1;
  localparam logic [3:0] INS_EXT_A = 4'h0;
  localparam logic [3:0] INS_EXT_B = 4'h4;
  localparam logic [1:0] INS_EXT_HI = 2'h3;
  localparam int RESULT_W = 12;
  localparam int DIV_W = 3;
  localparam logic [3:0] SAMPLE_TICKS = 4'h4;
  localparam logic [3:0] CONV_TICKS = 4'hc;
  // Five bits: sixteen does not fit the four-bit tick counters
  localparam logic [4:0] TOTAL_TICKS = 5'h10;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b10
  } adcc_state_t;

endpackage : adcc_pkg
`default_nettype wire

// [src/adcc_clk_div.sv]
`timescale 1ns/1ps
`default_nettype none
module adcc_clk_div
  import adcc_pkg::*;
#(
  parameter int CNT_W = 7
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [DIV_W-1:0] divSel,
  output logic tick
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] mask;

  // Mask of low bits that must be all ones: period is 2**divSel
  assign mask = CNT_W'((1 << divSel) - 1);
  assign tick = ((cnt_q & mask) == mask);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  a_tick_phase: assert property (@(posedge clk) disable iff (!rst_b)
    (divSel == '0) |-> tick) else $error("undivided clock missed a tick");
  a_tick_single: assert property (@(posedge clk) disable iff (!rst_b)
    tick && (divSel != '0) |=> !tick || (divSel == '0)) else $error("divided tick too long");

endmodule : adcc_clk_div
`default_nettype wire

// [src/adcc_result_fmt.sv]
`timescale 1ns/1ps
`default_nettype none
module adcc_result_fmt
  import adcc_pkg::*;
(
  input wire logic [RESULT_W-1:0] code,
  input wire logic rightAlign,
  output logic [7:0] highByte,
  output logic [7:0] lowByte
);

  // Format 0 left-aligns the code, format 1 right-aligns it
  always_comb begin
    if (rightAlign) begin
      highByte = {4'h0, code[11:8]};
      lowByte = code[7:0];
    end else begin
      highByte = code[11:4];
      lowByte = {code[3:0], 4'h0};
    end
  end

endmodule : adcc_result_fmt
`default_nettype wire

// [src/adcc_top.sv]
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module adcc_top
  import adcc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [RESULT_W-1:0] adcCode,
  output logic analogPowerOn,
  output logic refSelVdd,
  output logic refSelPin,
  output logic refSelInternal,
  output logic refPinConnect,
  output logic [3:0] extChannelSel,
  output logic extChannelConnect,
  output logic [3:0] intInputSel,
  output logic intInputConnect,
  output logic sampleActive,
  output logic convertActive,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    adcc_state_t st;
    logic [3:0] tickCnt;
    logic busy;
    logic startBit;
    logic power;
    logic [3:0] extCh;
    logic [3:0] intSel;
    logic [DIV_W-1:0] div;
    logic fmt;
    logic [1:0] refSel;
    logic [7:0] resH;
    logic [7:0] resL;
    logic flag;
    logic ie;
    logic ge;
    logic irq;
    logic waitReq;
    logic [31:0] rdata;
    logic done;
    logic refVdd;
    logic refPin;
    logic refInt;
    logic refConn;
    logic extConn;
    logic intConn;
    logic sampleOn;
    logic convOn;
  } adcc_regs_t;

  adcc_regs_t r_q;
  adcc_regs_t r_d;

  logic tick;
  logic [7:0] fmtHigh;
  logic [7:0] fmtLow;
  logic wrAcc;
  logic rdReq;
  logic wrLane;
  logic startRise;
  logic startFall;
  logic extRoute;

  adcc_clk_div u_div (
    .clk(clk),
    .rst_b(rst_b),
    .divSel(r_q.div),
    .tick(tick)
  );

  adcc_result_fmt u_fmt (
    .code(adcCode),
    .rightAlign(r_q.fmt),
    .highByte(fmtHigh),
    .lowByte(fmtLow)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Every access waits one cycle; write commits on the edge waitrequest is low
  assign wrAcc = write && !r_q.waitReq;
  assign rdReq = read && r_q.waitReq;
  assign wrLane = wrAcc && byteenable[0];
  assign startRise = wrLane && (address == OFS_CTRL0) && writedata[START_BIT] && !r_q.startBit;
  assign startFall = wrLane && (address == OFS_CTRL0) && !writedata[START_BIT] && r_q.startBit;
  assign extRoute = (r_q.intSel == INS_EXT_A) || (r_q.intSel == INS_EXT_B) ||
                    (r_q.intSel[3:2] == INS_EXT_HI);

  always_comb begin
    r_d = r_q;
    r_d.done = 1'b0;

    // ---------------------------------------------------------------
    // Bus handshake and register writes
    // ---------------------------------------------------------------
    if ((read || write) && r_q.waitReq) begin
      r_d.waitReq = 1'b0;
    end else begin
      r_d.waitReq = 1'b1;
    end
    if (rdReq) begin
      r_d.rdata = 32'h0;
      case (address)
        OFS_CTRL0: begin
          r_d.rdata[CH_LSB +: 4] = r_q.extCh;
          r_d.rdata[PWR_BIT] = r_q.power;
          r_d.rdata[BUSY_BIT] = r_q.busy;
          r_d.rdata[START_BIT] = r_q.startBit;
        end
        OFS_CTRL1: begin
          r_d.rdata[DIV_LSB +: DIV_W] = r_q.div;
          r_d.rdata[FMT_BIT] = r_q.fmt;
          r_d.rdata[INS_LSB +: 4] = r_q.intSel;
        end
        OFS_CTRL2: r_d.rdata[REF_LSB +: 2] = r_q.refSel;
        OFS_RESH: r_d.rdata[7:0] = r_q.resH;
        OFS_RESL: r_d.rdata[7:0] = r_q.resL;
        OFS_IRQ_STAT: r_d.rdata[FLAG_BIT] = r_q.flag;
        OFS_IRQ_MASK: r_d.rdata[FLAG_BIT] = r_q.ie;
        OFS_GIE: r_d.rdata[FLAG_BIT] = r_q.ge;
        default: r_d.rdata = 32'h0;
      endcase
    end
    if (wrLane) begin
      case (address)
        OFS_CTRL0: begin
          r_d.extCh = writedata[CH_LSB +: 4];
          r_d.power = writedata[PWR_BIT];
          r_d.startBit = writedata[START_BIT];
        end
        OFS_CTRL1: begin
          r_d.div = writedata[DIV_LSB +: DIV_W];
          r_d.fmt = writedata[FMT_BIT];
          r_d.intSel = writedata[INS_LSB +: 4];
        end
        OFS_CTRL2: r_d.refSel = writedata[REF_LSB +: 2];
        OFS_IRQ_STAT: begin
          if (writedata[FLAG_BIT]) begin
            r_d.flag = 1'b0;
          end
        end
        OFS_IRQ_MASK: r_d.ie = writedata[FLAG_BIT];
        OFS_GIE: r_d.ge = writedata[FLAG_BIT];
        default: r_d.flag = r_d.flag;
      endcase
    end

    // ---------------------------------------------------------------
    // Conversion sequencer
    // ---------------------------------------------------------------
    case (r_q.st)
      ST_SAMPLE: begin
        if (tick) begin
          if (r_q.tickCnt == SAMPLE_TICKS - 4'h1) begin
            r_d.st = ST_CONVERT;
            r_d.tickCnt = 4'h0;
          end else begin
            r_d.tickCnt = r_q.tickCnt + 4'h1;
          end
        end
      end
      ST_CONVERT: begin
        if (tick) begin
          if (r_q.tickCnt == CONV_TICKS - 4'h1) begin
            r_d.st = ST_IDLE;
            r_d.busy = 1'b0;
            r_d.resH = fmtHigh;
            r_d.resL = fmtLow;
            r_d.flag = 1'b1;
            r_d.done = 1'b1;
            r_d.tickCnt = 4'h0;
          end else begin
            r_d.tickCnt = r_q.tickCnt + 4'h1;
          end
        end
      end
      ST_IDLE: r_d.tickCnt = 4'h0;
      default: r_d.st = ST_IDLE;
    endcase
    if (startRise) begin
      r_d.st = ST_IDLE;
      r_d.busy = 1'b0;
      r_d.tickCnt = 4'h0;
    end else if (startFall && r_q.power) begin
      r_d.st = ST_SAMPLE;
      r_d.busy = 1'b1;
      r_d.tickCnt = 4'h0;
    end
    // Power off aborts any conversion; the old result is kept
    if (!r_d.power) begin
      r_d.st = ST_IDLE;
      r_d.busy = 1'b0;
      r_d.tickCnt = 4'h0;
    end

    // ---------------------------------------------------------------
    // Registered analog controls and interrupt
    // ---------------------------------------------------------------
    r_d.refVdd = (r_q.refSel == REF_VDD);
    r_d.refPin = (r_q.refSel == REF_PIN);
    r_d.refInt = r_q.refSel[1];
    r_d.refConn = (r_q.refSel == REF_PIN) && r_q.power;
    r_d.extConn = extRoute && r_q.power;
    r_d.intConn = !extRoute && r_q.power;
    r_d.sampleOn = (r_q.st == ST_SAMPLE);
    r_d.convOn = (r_q.st == ST_CONVERT);
    r_d.irq = r_q.flag && r_q.ie && r_q.ge;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_q <= '{st: ST_IDLE, waitReq: 1'b1, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  assign readdata = r_q.rdata;
  assign waitrequest = r_q.waitReq;
  assign analogPowerOn = r_q.power;
  assign refSelVdd = r_q.refVdd;
  assign refSelPin = r_q.refPin;
  assign refSelInternal = r_q.refInt;
  assign refPinConnect = r_q.refConn;
  assign extChannelSel = r_q.extCh;
  assign extChannelConnect = r_q.extConn;
  assign intInputSel = r_q.intSel;
  assign intInputConnect = r_q.intConn;
  assign sampleActive = r_q.sampleOn;
  assign convertActive = r_q.convOn;
  assign irq = r_q.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [4:0] convTicks_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      convTicks_q <= '0;
    end else if (r_q.st == ST_IDLE) begin
      convTicks_q <= '0;
    end else if (tick) begin
      convTicks_q <= convTicks_q + 5'h1;
    end
  end

  // Launch only when power stays on through the committing write
  sequence s_launch;
    startFall && r_q.power && writedata[PWR_BIT];
  endsequence

  sequence s_running;
    r_q.busy && (r_q.st == ST_SAMPLE);
  endsequence

  a_launch_busy: assert property (@(posedge clk) disable iff (!rst_b)
    s_launch |=> s_running) else $error("launch did not set busy");
  a_rise_reset: assert property (@(posedge clk) disable iff (!rst_b)
    startRise |=> (r_q.st == ST_IDLE) && !r_q.busy) else $error("rising start did not reset");
  a_conv_length: assert property (@(posedge clk) disable iff (!rst_b)
    r_q.done |-> ($past(convTicks_q) == 5'(TOTAL_TICKS) - 5'h1)) else $error("conversion not 16 ticks");
  a_done_result: assert property (@(posedge clk) disable iff (!rst_b)
    r_q.done |-> !r_q.busy && r_q.flag && (r_q.resH == $past(fmtHigh)) && (r_q.resL == $past(fmtLow)))
    else $error("result not loaded with busy clear");
  a_busy_span: assert property (@(posedge clk) disable iff (!rst_b)
    (r_q.st != ST_IDLE) |-> r_q.busy) else $error("busy low during conversion");
  a_irq_gate: assert property (@(posedge clk) disable iff (!rst_b)
    ##1 (irq == ($past(r_q.flag) && $past(r_q.ie) && $past(r_q.ge)))) else $error("interrupt gating wrong");
  a_ref_decode: assert property (@(posedge clk) disable iff (!rst_b)
    ##1 (refSelInternal == $past(r_q.refSel[1])) && !(refSelInternal && refPinConnect))
    else $error("reference decode wrong");
  a_route_ext: assert property (@(posedge clk) disable iff (!rst_b)
    (extRoute && r_q.power) |=> extChannelConnect && !intInputConnect) else $error("external route wrong");
  a_route_int: assert property (@(posedge clk) disable iff (!rst_b)
    (!extRoute && r_q.power) |=> intInputConnect && !extChannelConnect) else $error("internal route wrong");
  a_power_off: assert property (@(posedge clk) disable iff (!rst_b)
    !r_q.power |-> !r_q.busy && !analogPowerOn ##1 !extChannelConnect && !refPinConnect)
    else $error("power off left circuitry active");

endmodule : adcc_top
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb import adcc_pkg::*;;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [3:0] byteenable = 4'h1;
  logic [RESULT_W-1:0] adcCode = 12'h000;
  logic [31:0] readdata;
  logic waitrequest, analogPowerOn, refSelVdd, refSelPin, refSelInternal, refPinConnect;
  logic extChannelConnect, intInputConnect, sampleActive, convertActive, irq;
  logic [3:0] extChannelSel, intInputSel;
  logic [7:0] q;
  logic [7:0] hiExp = 8'h00;
  logic [7:0] loExp = 8'h00;
  logic ext;
  int badCount = 0;
  int checksDone = 0;
  int sCnt = 0;
  int cCnt = 0;

  always #12.5 clk = ~clk;

  // Phase lengths are measured at the ports, not read back from registers
  always @(posedge clk) begin
    if (sampleActive === 1'b1)
      sCnt <= sCnt + 1;
    if (convertActive === 1'b1)
      cCnt <= cCnt + 1;
  end

  adcc_top adcc_top_i (.clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .adcCode(adcCode), .analogPowerOn(analogPowerOn), .refSelVdd(refSelVdd), .refSelPin(refSelPin),
    .refSelInternal(refSelInternal), .refPinConnect(refPinConnect), .extChannelSel(extChannelSel),
    .extChannelConnect(extChannelConnect), .intInputSel(intInputSel),
    .intInputConnect(intInputConnect), .sampleActive(sampleActive), .convertActive(convertActive),
    .irq(irq));

  // ------------------------------------------------------------
  // Bus access and comparison
  // ------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  task automatic chkv(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checksDone++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chkv

  task automatic chkb(input logic got, input logic exp, input string msg);
    checksDone++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch at %0t: %s got %b expected %b", $time, msg, got, exp);
    end
  endtask : chkb

  // Request held until waitrequest is seen low; data taken at that edge
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be,
                     output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= {24'h000000, d};
    byteenable <= be;
    write <= w;
    read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    r = readdata[7:0];
    write <= 1'b0;
    read <= 1'b0;
    if (n >= 50) begin
      badCount++;
      $display("mismatch at %0t: bus access hung", $time);
    end
  endtask : acc

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    acc(1'b1, a, d, 4'h1, q);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [7:0] r);
    acc(1'b0, a, 8'h00, 4'h1, r);
  endtask : rd

  // Decoded outputs lag the committing edge by one register stage
  task automatic settle;
    repeat (2) @(posedge clk);
  endtask : settle

  task automatic conv(input logic [2:0] dv, input logic fmt, input logic [11:0] code);
    int s0, c0, n;
    logic [7:0] r;
    n = 0;
    adcCode <= code;
    wr(OFS_CTRL1, {4'h0, fmt, dv});
    s0 = sCnt;
    c0 = cCnt;
    wr(OFS_CTRL0, 8'h51);
    wr(OFS_CTRL0, 8'h11);
    rd(OFS_CTRL0, r);
    chkb(r[BUSY_BIT], 1'b1, "busy during conversion");
    rd(OFS_RESH, r);
    chkv(r, hiExp, "result held while busy");
    do begin
      rd(OFS_CTRL0, r);
      n++;
    end while (r[BUSY_BIT] !== 1'b0 && n < 200);
    chkb(r[BUSY_BIT], 1'b0, "busy clears");
    hiExp = fmt ? {4'h0, code[11:8]} : code[11:4];
    loExp = fmt ? code[7:0] : {code[3:0], 4'h0};
    rd(OFS_RESH, r);
    chkv(r, hiExp, "result high byte");
    rd(OFS_RESL, r);
    chkv(r, loExp, "result low byte");
    chkv(8'(cCnt - c0), 8'(12 << dv), "convert length");
    chkb((sCnt - s0) > (3 << dv) && (sCnt - s0) <= (4 << dv), 1'b1, "sample length");
    rd(OFS_IRQ_STAT, r);
    chkb(r[FLAG_BIT], 1'b1, "flag set with irq disabled");
  endtask : conv

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    chkb(waitrequest, 1'b1, "idle waitrequest");
    for (int i = 0; i < 8; i++) begin
      rd(5'(i * 4), q);
      chkv(q, 8'h00, "reset value");
    end
    rd(5'h02, q);
    chkv(q, 8'h00, "unmapped read");
    acc(1'b1, OFS_GIE, 8'h01, 4'h0, q);
    rd(OFS_GIE, q);
    chkv(q, 8'h00, "disabled lane write");
    wr(OFS_CTRL0, 8'h13);
    for (int r = 0; r < 4; r++) begin
      wr(OFS_CTRL2, 8'(r));
      settle();
      chkb(refSelVdd, r == 0, "supply reference");
      chkb(refSelPin, r == 1, "pin reference");
      chkb(refSelInternal, r >= 2, "internal reference");
      chkb(refPinConnect, r == 1, "reference pin connect");
    end
    for (int i = 0; i < 16; i++) begin
      wr(OFS_CTRL1, 8'(i << INS_LSB));
      settle();
      ext = (i == 0) || (i == 4) || (i >= 12);
      chkb(extChannelConnect, ext, "external route");
      chkb(intInputConnect, !ext, "internal route");
      chkv({4'h0, intInputSel}, 8'(i), "internal select");
      chkv({4'h0, extChannelSel}, 8'h03, "channel select");
    end
    wr(OFS_CTRL2, 8'h01);
    wr(OFS_CTRL0, 8'h03);
    settle();
    chkb(analogPowerOn, 1'b0, "power off");
    chkb(refPinConnect, 1'b0, "pin off when unpowered");
    chkb(extChannelConnect, 1'b0, "route off when unpowered");
    conv(3'h0, 1'b0, 12'hfff);
    conv(3'h1, 1'b1, 12'ha5c);
    conv(3'h3, 1'b0, 12'h3c7);
    settle();
    chkb(irq, 1'b0, "irq both disabled");
    wr(OFS_IRQ_MASK, 8'h01);
    settle();
    chkb(irq, 1'b0, "irq global disabled");
    wr(OFS_GIE, 8'h01);
    settle();
    chkb(irq, 1'b1, "irq enabled");
    wr(OFS_IRQ_MASK, 8'h00);
    settle();
    chkb(irq, 1'b0, "irq masked");
    wr(OFS_IRQ_MASK, 8'h01);
    wr(OFS_IRQ_STAT, 8'h01);
    settle();
    chkb(irq, 1'b0, "irq after clear");
    rd(OFS_IRQ_STAT, q);
    chkv(q, 8'h00, "flag cleared");
    // Rising start and power loss mid-conversion must abort without touching the result
    wr(OFS_CTRL0, 8'h51);
    wr(OFS_CTRL0, 8'h11);
    wr(OFS_CTRL0, 8'h51);
    rd(OFS_CTRL0, q);
    chkb(q[BUSY_BIT], 1'b0, "rising start resets");
    wr(OFS_CTRL0, 8'h11);
    wr(OFS_CTRL0, 8'h01);
    rd(OFS_CTRL0, q);
    chkb(q[BUSY_BIT], 1'b0, "abort clears busy");
    repeat (200) @(posedge clk);
    rd(OFS_RESH, q);
    chkv(q, hiExp, "result kept on abort");
    rd(OFS_IRQ_STAT, q);
    chkv(q, 8'h00, "no flag on abort");
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk);
    badCount++;
    conclude();
  end
endmodule : tb
`default_nettype wire
